// >>> design/cirs_pkg.sv
/*
 * Constants, types and register map for the comparator interrupt and
 * status register bank.
 * Assumes a 32-bit AXI4-Lite bus, 250 MHz clock, two comparators.
 */
package cirs_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_START = 6'h01;
    localparam logic [5:0] IDX_ENCLR = 6'h04;
    localparam logic [5:0] IDX_ENSET = 6'h05;
    localparam logic [5:0] IDX_FLAGS = 6'h06;
    localparam logic [5:0] IDX_STATE = 6'h08;
    localparam logic [5:0] IDX_READY = 6'h09;
    localparam logic [5:0] IDX_TRIG = 6'h0a;
    localparam logic [5:0] IDX_WINCTL = 6'h0c;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned BIT_WIN = 4;
    localparam int unsigned BIT_BUSY = 7;
    localparam int unsigned WPOS_LSB = 4;
    localparam int unsigned WSEL_LSB = 1;
    localparam int unsigned WON_BIT = 0;
    localparam logic [2:0] RST_ENABLE = 3'h0;
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam logic [2:0] RST_WINCTL = 3'h0;
    localparam logic [1:0] CMP_IMPL = 2'h3;
    localparam logic WIN_IMPL = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned SETTLE_NS = 8;
    localparam int unsigned SETTLE_CYC =
        (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WPOS_ABOVE = 2'h0,
        WPOS_INSIDE = 2'h1,
        WPOS_BELOW = 2'h2
    } cirs_wpos_e;

    typedef enum logic [1:0] {
        WSEL_ABOVE = 2'h0,
        WSEL_INSIDE = 2'h1,
        WSEL_BELOW = 2'h2,
        WSEL_OUTSIDE = 2'h3
    } cirs_wsel_e;

    typedef enum logic [1:0] {
        CSEL_TOGGLE = 2'h0,
        CSEL_RISE = 2'h1,
        CSEL_FALL = 2'h2,
        CSEL_DONE = 2'h3
    } cirs_csel_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_LAUNCH = 2'b01,
        RD_WAIT = 2'b10,
        RD_RESP = 2'b11
    } cirs_rd_e;

    typedef struct packed {
        logic [1:0] out;
        logic [1:0] ready;
        logic [1:0] enable;
        logic [1:0] single;
        logic [3:0] irq_select;
    } cirs_cmp_s;

    typedef struct packed {
        logic [1:0] window_irq_select;
        logic window_mode_on;
    } cirs_winctl_s;

endpackage : cirs_pkg

// >>> design/cirs_top.sv
/*
 * Interrupt enable, flag, state and ready registers of a two-channel
 * comparator with window pair, on an AXI4-Lite slave port.
 * Assumes comparator outputs and ready levels synchronous to aclk and a
 * one-cycle sync_done pulse from the slower domain after each window
 * control update.
 */
// The AXI4-Lite register port was left to the implementer.
// Notes on behaviour
// - writing one to comparator enable-clear bit disables its interrupt
// - writing one to window enable-clear bit disables window interrupt
// - enable-set and enable-clear views share one set of enable bits
// - writing one to window enable-set bit enables window interrupt
// - writing one to comparator enable-set bit enables its interrupt
// - comparator flag set on selected condition; request needs enable too
// - window flag set on selected condition; requests when enabled
// - writing one clears a flag; zero leaves it unchanged
// - absent comparator reads zero in flag, ready and state bits
// - window position above 0, inside 1, below 2; zero if absent
// - state bit mirrors comparator output; valid only while ready
// - sync busy rises at domain transfer start, falls when done
// - ready bit reads one exactly while comparator output is ready
// - trigger-state register returns same contents as state register
// - reading trigger-state launches all enabled single-shot comparators
// - that read stalls until every enabled comparator is ready
// - busy comparator is waited for, not relaunched
// - reserved bits read zero; software writes zeros there
// - window select chooses above, inside, below or outside
// - window mode on pairs comparators 0 and 1; off otherwise
// - start bit launches one shot only if enabled and single-shot
`timescale 1ns/1ps
module cirs_top (
    input wire logic aclk, // clock, 250 MHz
    input wire logic aresetn, // sync reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic [2:0] s_axi_awprot, // write protection, unused
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic [2:0] s_axi_arprot, // read protection, unused
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire cirs_pkg::cirs_cmp_s cmp, // comparator core side
    input wire logic sync_done, // window control transfer finished
    output logic [1:0] one_shot_trigger, // start pulse per comparator
    output cirs_pkg::cirs_winctl_s window_ctrl, // window control to core
    output logic irq // interrupt request
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0] en_q; // {window, comp1, comp0}
    logic [2:0] flags_q;
    logic [2:0] flags_d;
    logic [2:0] ev_d;
    cirs_pkg::cirs_winctl_s winctl_q;
    logic busy_q;
    logic [1:0] prev_out_q;
    logic [1:0] prev_rdy_q;
    logic [1:0] prev_wpos_q;
    logic [1:0] wpos;
    logic [1:0] start_d;
    logic [1:0] trig_q;
    logic irq_q;

    logic aw_full_q;
    logic w_full_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [5:0] aw_idx_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic do_wr;
    logic wr_en;

    cirs_pkg::cirs_rd_e rd_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [5:0] ar_idx_q;
    logic [1:0] settle_q;
    logic all_ready;
    logic [7:0] state_byte;
    logic [7:0] rd_byte;
    logic rd_hit;

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign one_shot_trigger = trig_q;
    assign window_ctrl = winctl_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // write channels
    // ------------------------------------------------------------
    assign do_wr = aw_full_q && w_full_q && !bvalid_q;
    assign wr_en = do_wr && wlane_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b0;
            aw_idx_q <= 6'h00;
        end else if (s_axi_awvalid && awready_q) begin
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
            aw_idx_q <= s_axi_awaddr[7:2];
        end else if (bvalid_q && s_axi_bready) begin
            aw_full_q <= 1'b0;
        end else if (!aw_full_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else if (s_axi_wvalid && wready_q) begin
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end else if (bvalid_q && s_axi_bready) begin
            w_full_q <= 1'b0;
        end else if (!w_full_q) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= cirs_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            if (aw_idx_q == cirs_pkg::IDX_START ||
                    aw_idx_q == cirs_pkg::IDX_ENCLR ||
                    aw_idx_q == cirs_pkg::IDX_ENSET ||
                    aw_idx_q == cirs_pkg::IDX_FLAGS ||
                    aw_idx_q == cirs_pkg::IDX_STATE ||
                    aw_idx_q == cirs_pkg::IDX_READY ||
                    aw_idx_q == cirs_pkg::IDX_TRIG ||
                    aw_idx_q == cirs_pkg::IDX_WINCTL) begin
                bresp_q <= cirs_pkg::RESP_OKAY;
            end else begin
                bresp_q <= cirs_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt enables
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= cirs_pkg::RST_ENABLE;
        end else if (wr_en && aw_idx_q == cirs_pkg::IDX_ENCLR) begin
            en_q <= en_q & ~{wbyte_q[cirs_pkg::BIT_WIN], wbyte_q[1:0]};
        end else if (wr_en && aw_idx_q == cirs_pkg::IDX_ENSET) begin
            en_q <= en_q | {wbyte_q[cirs_pkg::BIT_WIN], wbyte_q[1:0]};
        end
    end

    // ------------------------------------------------------------
    // window control and sync busy
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            winctl_q <= cirs_pkg::RST_WINCTL;
        end else if (wr_en && aw_idx_q == cirs_pkg::IDX_WINCTL) begin
            winctl_q.window_irq_select <=
                wbyte_q[cirs_pkg::WSEL_LSB +: 2];
            winctl_q.window_mode_on <= wbyte_q[cirs_pkg::WON_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
        end else if (wr_en && aw_idx_q == cirs_pkg::IDX_WINCTL) begin
            busy_q <= 1'b1;
        end else if (sync_done) begin
            busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // events and flags
    // ------------------------------------------------------------
    always_comb begin
        if (cmp.out[0]) begin
            wpos = cirs_pkg::WPOS_ABOVE;
        end else if (cmp.out[1]) begin
            wpos = cirs_pkg::WPOS_INSIDE;
        end else begin
            wpos = cirs_pkg::WPOS_BELOW;
        end
    end

    always_comb begin
        ev_d = 3'h0;
        for (int i = 0; i < 2; i++) begin
            case (cirs_pkg::cirs_csel_e'(cmp.irq_select[2*i +: 2]))
                cirs_pkg::CSEL_TOGGLE: ev_d[i] = cmp.ready[i] &&
                    prev_rdy_q[i] && cmp.out[i] != prev_out_q[i];
                cirs_pkg::CSEL_RISE: ev_d[i] = cmp.ready[i] &&
                    prev_rdy_q[i] && cmp.out[i] && !prev_out_q[i];
                cirs_pkg::CSEL_FALL: ev_d[i] = cmp.ready[i] &&
                    prev_rdy_q[i] && !cmp.out[i] && prev_out_q[i];
                default: ev_d[i] = cmp.ready[i] && !prev_rdy_q[i];
            endcase
        end
        if (winctl_q.window_mode_on && &cmp.ready && &prev_rdy_q &&
                wpos != prev_wpos_q) begin
            case (winctl_q.window_irq_select)
                cirs_pkg::WSEL_ABOVE: ev_d[2] = wpos == cirs_pkg::WPOS_ABOVE;
                cirs_pkg::WSEL_INSIDE:
                    ev_d[2] = wpos == cirs_pkg::WPOS_INSIDE;
                cirs_pkg::WSEL_BELOW: ev_d[2] = wpos == cirs_pkg::WPOS_BELOW;
                default: ev_d[2] = prev_wpos_q == cirs_pkg::WPOS_INSIDE;
            endcase
        end
        ev_d = ev_d & {cirs_pkg::WIN_IMPL, cirs_pkg::CMP_IMPL};
    end

    always_comb begin
        flags_d = flags_q;
        if (wr_en && aw_idx_q == cirs_pkg::IDX_FLAGS) begin
            flags_d = flags_q & ~{wbyte_q[cirs_pkg::BIT_WIN], wbyte_q[1:0]};
        end
        flags_d = flags_d | ev_d; // set wins over clear
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= cirs_pkg::RST_FLAGS;
            prev_out_q <= 2'h0;
            prev_rdy_q <= 2'h0;
            prev_wpos_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            prev_out_q <= cmp.out;
            prev_rdy_q <= cmp.ready;
            prev_wpos_q <= wpos;
            irq_q <= |(flags_q & en_q);
        end
    end

    // ------------------------------------------------------------
    // read data and trigger-state read sequencing
    // ------------------------------------------------------------
    assign all_ready = ((cmp.ready | ~cmp.enable) & cirs_pkg::CMP_IMPL)
        == cirs_pkg::CMP_IMPL;

    assign state_byte = {2'h0,
        (winctl_q.window_mode_on && cirs_pkg::WIN_IMPL) ? wpos : 2'h0,
        2'h0, cmp.out & cirs_pkg::CMP_IMPL};

    always_comb begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        if (ar_idx_q == cirs_pkg::IDX_ENCLR ||
                ar_idx_q == cirs_pkg::IDX_ENSET) begin
            rd_byte = {3'h0, en_q[2], 2'h0, en_q[1:0]};
        end else if (ar_idx_q == cirs_pkg::IDX_FLAGS) begin
            rd_byte = {3'h0, flags_q[2], 2'h0, flags_q[1:0]};
        end else if (ar_idx_q == cirs_pkg::IDX_STATE ||
                ar_idx_q == cirs_pkg::IDX_TRIG) begin
            rd_byte = state_byte;
        end else if (ar_idx_q == cirs_pkg::IDX_READY) begin
            rd_byte = {busy_q, 5'h00, cmp.ready & cirs_pkg::CMP_IMPL};
        end else if (ar_idx_q == cirs_pkg::IDX_WINCTL) begin
            rd_byte = {5'h00, winctl_q};
        end else if (ar_idx_q == cirs_pkg::IDX_START) begin
            rd_byte = 8'h00;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_q <= cirs_pkg::RD_IDLE;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= cirs_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            ar_idx_q <= 6'h00;
            settle_q <= 2'h0;
        end else begin
            case (rd_q)
                cirs_pkg::RD_IDLE: begin
                    if (s_axi_arvalid && arready_q) begin
                        arready_q <= 1'b0;
                        ar_idx_q <= s_axi_araddr[7:2];
                        rd_q <= (s_axi_araddr[7:2] == cirs_pkg::IDX_TRIG)
                            ? cirs_pkg::RD_LAUNCH : cirs_pkg::RD_WAIT;
                        settle_q <= 2'h0;
                    end else begin
                        arready_q <= 1'b1;
                    end
                end
                cirs_pkg::RD_LAUNCH: begin
                    settle_q <= 2'(cirs_pkg::SETTLE_CYC);
                    rd_q <= cirs_pkg::RD_WAIT;
                end
                cirs_pkg::RD_WAIT: begin
                    if (settle_q != 2'h0) begin
                        settle_q <= settle_q - 2'h1;
                    end else if (ar_idx_q != cirs_pkg::IDX_TRIG ||
                            all_ready) begin
                        rvalid_q <= 1'b1;
                        rdata_q <= {24'h00_0000, rd_byte};
                        rresp_q <= rd_hit ? cirs_pkg::RESP_OKAY
                            : cirs_pkg::RESP_SLVERR;
                        rd_q <= cirs_pkg::RD_RESP;
                    end
                end
                default: begin
                    if (s_axi_rready) begin
                        rvalid_q <= 1'b0;
                        rd_q <= cirs_pkg::RD_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // single-shot launches
    // ------------------------------------------------------------
    always_comb begin
        start_d = 2'h0;
        if (wr_en && aw_idx_q == cirs_pkg::IDX_START) begin
            start_d = wbyte_q[1:0];
        end
        if (rd_q == cirs_pkg::RD_LAUNCH) begin
            start_d = start_d | (cmp.single & cmp.ready);
        end
        start_d = start_d & cmp.enable & cmp.single & cirs_pkg::CMP_IMPL;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_q <= 2'h0;
        end else begin
            trig_q <= start_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_enclr_clears: assert property (
        wr_en && aw_idx_q == cirs_pkg::IDX_ENCLR && wbyte_q[0]
        |=> !en_q[0])
        else $error("enable clear did not disable comparator 0");
    a_enset_sets: assert property (
        wr_en && aw_idx_q == cirs_pkg::IDX_ENSET && wbyte_q[1]
        |=> en_q[1])
        else $error("enable set did not enable comparator 1");
    a_win_enset: assert property (
        wr_en && aw_idx_q == cirs_pkg::IDX_ENSET && !wbyte_q[4]
        |=> en_q[2] == $past(en_q[2]))
        else $error("zero write changed window enable");
    a_flag_set_wins: assert property (
        ev_d[0] |=> flags_q[0])
        else $error("flag event lost");
    a_flag_clear: assert property (
        wr_en && aw_idx_q == cirs_pkg::IDX_FLAGS && wbyte_q[1] && !ev_d[1]
        |=> !flags_q[1])
        else $error("flag not cleared by one");
    a_irq_follows: assert property (
        |(flags_q & en_q) |=> irq_q)
        else $error("interrupt not raised");
    a_irq_low: assert property (
        !(|(flags_q & en_q)) |=> !irq_q)
        else $error("interrupt raised without cause");
    a_sync_busy: assert property (
        wr_en && aw_idx_q == cirs_pkg::IDX_WINCTL |=> busy_q)
        else $error("sync busy not set");
    a_trig_stall: assert property (
        rd_q == cirs_pkg::RD_WAIT && ar_idx_q == cirs_pkg::IDX_TRIG &&
        !all_ready |=> !rvalid_q)
        else $error("trigger read answered before ready");
    a_no_relaunch: assert property (
        rd_q == cirs_pkg::RD_LAUNCH && !cmp.ready[0] |=> !trig_q[0])
        else $error("busy comparator relaunched");
    a_trig_launch: assert property (
        rd_q == cirs_pkg::RD_LAUNCH && cmp.enable[0] && cmp.single[0] &&
        cmp.ready[0] |=> trig_q[0])
        else $error("single-shot comparator not launched");

    c_trig_read: cover property (rd_q == cirs_pkg::RD_LAUNCH ##[1:20] rvalid_q);
    c_irq_seen: cover property (!irq_q ##1 irq_q);
    c_win_flag: cover property (ev_d[2]);

endmodule : cirs_top

// >>> testbench/cirs_core_model.sv
/* comparator core model: ready levels, one-shot timing, sync answer.
   assumes one aclk domain and an active-low synchronous reset. */
`timescale 1ns/1ps
module cirs_core_model #(
    parameter int DELAY = 10, // one-shot conversion cycles
    parameter int SYNC = 20 // domain transfer cycles
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic [1:0] trig, // one-shot starts
    input wire cirs_pkg::cirs_winctl_s win, // window control
    input wire logic [1:0] lvl, // analog outcome
    input wire logic [1:0] en, // comparator enables
    input wire logic [1:0] sgl, // single-shot modes
    output cirs_pkg::cirs_cmp_s cmp, // core status
    output logic sync_done // transfer finished pulse
);
    int cnt[2];
    int scnt;
    logic [1:0] rdy;
    cirs_pkg::cirs_winctl_s win_q;
    // output follows the level once ready, held low while converting
    assign cmp = '{out: rdy & lvl, ready: rdy, enable: en,
                   single: sgl, irq_select: 4'h0};
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn || !en[i]) begin
                cnt[i] <= 0;
                rdy[i] <= 1'b0;
            end else if (trig[i] && sgl[i]) begin
                cnt[i] <= DELAY;
                rdy[i] <= 1'b0;
            end else if (cnt[i] > 1) begin
                cnt[i] <= cnt[i] - 1;
            end else begin
                cnt[i] <= 0;
                rdy[i] <= 1'b1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        win_q <= win;
        sync_done <= aresetn && scnt == 1;
        if (!aresetn) begin
            scnt <= 0;
        end else if (win != win_q) begin
            scnt <= SYNC;
        end else if (scnt > 0) begin
            scnt <= scnt - 1;
        end
    end
endmodule : cirs_core_model

// >>> testbench/cirs_top_test.sv
/* self-checking bench for the comparator irq and status registers.
   assumes cirs_top and cirs_core_model; 250 MHz aclk. */
`timescale 1ns/1ps
module cirs_top_test;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, trig_n, rd_n, err_count, total_checks;
    logic awready, wready, bvalid, arready, rvalid, irq, sync_done;
    logic [1:0] bresp, rresp, trig, lvl, en, sgl;
    logic [31:0] rdata;
    cirs_pkg::cirs_cmp_s cmp;
    cirs_pkg::cirs_winctl_s win;
    localparam logic [1:0] OK = cirs_pkg::RESP_OKAY;
    cirs_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cmp(cmp), .sync_done(sync_done),
        .one_shot_trigger(trig), .window_ctrl(win), .irq(irq));
    cirs_core_model core (.aclk(aclk), .aresetn(aresetn), .trig(trig),
        .win(win), .lvl(lvl), .en(en), .sgl(sgl), .cmp(cmp),
        .sync_done(sync_done));
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) trig_n <= trig_n + trig[0] + trig[1];
    // -----------------------------------------------------------
    // bus and check helpers
    // -----------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [5:0] i, input logic [7:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [5:0] i, input logic [7:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        rd_n = 0;
        do begin
            @(posedge aclk);
            rd_n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rdata", rdata, {24'h0, e});
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask : rd
    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_reset;
        logic [5:0] ix[7] = '{6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a,
                             6'h0c};
        foreach (ix[k]) rd(ix[k], 8'h00, OK);
        rd(6'h3f, 8'h00, cirs_pkg::RESP_SLVERR);
        wr(6'h03, 8'h01, cirs_pkg::RESP_SLVERR);
    endtask : t_reset
    task automatic t_enable;
        wr(cirs_pkg::IDX_ENSET, 8'h13, OK);
        rd(cirs_pkg::IDX_ENCLR, 8'h13, OK);
        wr(cirs_pkg::IDX_ENCLR, 8'h01, OK);
        wr(cirs_pkg::IDX_ENSET, 8'h00, OK);
        rd(cirs_pkg::IDX_ENSET, 8'h12, OK);
        wr(cirs_pkg::IDX_ENCLR, 8'h10, OK);
        rd(cirs_pkg::IDX_ENCLR, 8'h02, OK);
    endtask : t_enable
    task automatic t_flags;
        en <= 2'b11;
        repeat (5) @(posedge aclk);
        lvl <= 2'b01;
        repeat (4) @(posedge aclk);
        rd(cirs_pkg::IDX_FLAGS, 8'h01, OK);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(cirs_pkg::IDX_ENSET, 8'h01, OK);
        repeat (3) @(posedge aclk);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(cirs_pkg::IDX_FLAGS, 8'h00, OK);
        rd(cirs_pkg::IDX_FLAGS, 8'h01, OK);
        wr(cirs_pkg::IDX_FLAGS, 8'h01, OK);
        repeat (3) @(posedge aclk);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(cirs_pkg::IDX_STATE, 8'h01, OK);
        rd(cirs_pkg::IDX_READY, 8'h03, OK);
    endtask : t_flags
    task automatic t_window;
        wr(cirs_pkg::IDX_WINCTL, 8'h01, OK);
        rd(cirs_pkg::IDX_READY, 8'h83, OK);
        chk("win", {29'h0, win}, 32'h1);
        repeat (30) @(posedge aclk);
        rd(cirs_pkg::IDX_READY, 8'h03, OK);
        rd(cirs_pkg::IDX_STATE, 8'h01, OK);
        lvl <= 2'b10;
        rd(cirs_pkg::IDX_STATE, 8'h12, OK);
        lvl <= 2'b00;
        rd(cirs_pkg::IDX_STATE, 8'h20, OK);
        wr(cirs_pkg::IDX_FLAGS, 8'h13, OK);
        lvl <= 2'b01;
        repeat (4) @(posedge aclk);
        rd(cirs_pkg::IDX_FLAGS, 8'h11, OK);
        wr(cirs_pkg::IDX_WINCTL, 8'h00, OK);
        repeat (30) @(posedge aclk);
        rd(cirs_pkg::IDX_STATE, 8'h01, OK);
    endtask : t_window
    task automatic t_trigger;
        logic [31:0] b;
        sgl <= 2'b01;
        repeat (3) @(posedge aclk);
        b = trig_n;
        wr(cirs_pkg::IDX_START, 8'h01, OK);
        rd(cirs_pkg::IDX_TRIG, 8'h01, OK);
        chk("stall", {31'h0, rd_n > 4}, 32'h1);
        chk("starts", trig_n - b, 32'h1);
        rd(cirs_pkg::IDX_TRIG, 8'h01, OK);
        chk("starts", trig_n - b, 32'h2);
    endtask : t_trigger
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    initial begin
        #40000;
        err_count++;
        end_sim();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, lvl, en, sgl} = 54'h0;
        {trig_n, err_count, total_checks, rd_n} = 128'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_enable();
        t_flags();
        t_window();
        t_trigger();
        end_sim();
    end
endmodule : cirs_top_test
